// ### shared/trig_in_map.svh
`ifndef TRIG_IN_MAP_SVH
`define TRIG_IN_MAP_SVH
// ----------------------------------------
// Register byte offsets, one block per line
// ----------------------------------------
`define LINE_COUNT        5
`define CHAN_COUNT        4
`define LINE_STRIDE       12'h020
`define OFS_CONFIG        12'h000
`define OFS_THRESHOLD     12'h004
`define OFS_OUTPUTS       12'h100
`define OFS_LOADMODE      12'h104
`define OFS_COUPLING      12'h108
`define OFS_LINE_STATE    12'h10C
// ----------------------------------------
// Config field positions
// ----------------------------------------
`define CFG_EN_BIT        0
`define CFG_TYPE_LSB      4
`define CFG_SENS_LSB      8
`define CFG_CHAN_LSB      12
`define CFG_RESP_LSB      16
`define CFG_COND_LSB      24
`define CFG_RESET         32'h0000_0000
`endif

// ### shared/trig_in_pkg.sv
package trig_in_pkg;
  typedef enum logic [2:0]
  {
    type_rise, type_fall, type_high, type_low, type_state
  } trig_type_t;
  typedef enum logic [1:0] {sens_low, sens_mid, sens_high} sens_t;
  typedef enum logic [3:0]
  {
    resp_output_on, resp_output_off, resp_toggle, resp_source,
    resp_load_const_voltage, resp_load_const_current,
    resp_load_const_resistance, resp_independent_coupling,
    resp_series_coupling, resp_parallel_coupling
  } resp_t;
  typedef enum logic [1:0]
  {
    mode_source, mode_load_const_voltage, mode_load_const_current,
    mode_load_const_resistance
  } chan_mode_t;
  typedef enum logic [1:0]
  {
    independent_coupling, series_coupling, parallel_coupling
  } coupling_t;
  typedef enum logic [3:0]
  {
    cond_output_off, cond_output_on, cond_volt_above, cond_volt_below,
    cond_volt_equal, cond_curr_above, cond_curr_below, cond_curr_equal,
    cond_pow_above, cond_pow_below, cond_pow_equal, cond_auto
  } out_cond_t;
endpackage : trig_in_pkg

// ### src/trig_line_detect.sv
// ----------------------------------------
// One trigger line: synchroniser and detector
// ----------------------------------------
module trig_line_detect
(
  input  wire logic                    clk_sys,
  input  wire logic                    resetn,
  input  wire logic                    line_pin,
  input  wire logic                    enable,
  input  wire trig_in_pkg::trig_type_t trig_type,
  output logic                         fire
);
  logic sync_a;
  logic sync_b;
  logic sync_c;
  logic level;
  logic prev;
  logic armed;
  logic cond;

  // Three stages; the first feeds only the second
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      sync_c <= 1'b0;
    end
    else
    begin
      sync_a <= line_pin;
      sync_b <= sync_a;
      sync_c <= sync_b;
    end
  end

  // Accept a change once stages two and three agree
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      level <= 1'b0;
      prev  <= 1'b0;
    end
    else
    begin
      if (sync_b == sync_c)
        level <= sync_c;
      prev <= level;
    end
  end

  // Condition per trigger type; state fires on either edge
  always_comb
  begin
    case (trig_type)
      trig_in_pkg::type_rise:  cond = level & ~prev;
      trig_in_pkg::type_fall:  cond = ~level & prev;
      trig_in_pkg::type_high:  cond = level;
      trig_in_pkg::type_low:   cond = ~level;
      trig_in_pkg::type_state: cond = level ^ prev;
      default:                 cond = 1'b0;
    endcase
  end

  // Level types fire once, then wait for the level to change back
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
      armed <= 1'b1;
    else if (!cond)
      armed <= 1'b1;
    else if (enable)
      armed <= 1'b0;
  end

  assign fire = enable & cond & armed;
endmodule : trig_line_detect

// ### src/trig_in_ctrl.sv
// Function
// - Output-on response switches selected channels on
// - Output-off response switches selected channels off
// - Toggle response inverts selected channel outputs
// - Source response sets selected channels source
// - Load response sets voltage/current/resistance load
// - Coupling response sets first channel pair
// - Separate readable response per line
// - Three-level sensitivity stored per line; the detector does not use it
// - Sensitivity readable per line
// - Per-line mask of four channels
// - Channel mask readable per line
// - Selectable trigger type per line
// - Trigger type readable per line
// - Trigger output condition stored per line
// - Disabled line produces no action
//
// The register addresses and the AXI4-Lite register port are this design's own decisions.
`include "trig_in_map.svh"
module trig_in_ctrl
(
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic [4:0]  trig_pin,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [3:0]       chan_output_on,
  output logic [7:0]       chan_mode,
  output logic [1:0]       pair_coupling
);
  localparam int NL = `LINE_COUNT;
  localparam int NC = `CHAN_COUNT;

  // ----------------------------------------
  // Per-line configuration storage
  // ----------------------------------------
  logic                    line_en   [NL];
  trig_in_pkg::trig_type_t line_type [NL];
  trig_in_pkg::sens_t      line_sens [NL];
  logic [NC-1:0]           line_chan [NL];
  trig_in_pkg::resp_t      line_resp [NL];
  trig_in_pkg::out_cond_t  line_cond [NL];
  logic [31:0]             line_thr  [NL];
  logic [NL-1:0]           fire;
  logic [NL-1:0]           fire_seen;

  // ----------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------
  logic        aw_held;
  logic        w_held;
  logic [11:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        do_write;
  logic [2:0]  wr_line;
  logic [2:0]  rd_line;
  logic        wr_cfg_hit;
  logic        wr_thr_hit;
  logic        wr_glob_hit;
  logic [31:0] next_rdata;
  logic        rd_ok;
  logic [31:0] wmask;
  logic [31:0] cfg_word [NL];

  // Address and data may arrive in either order
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 12'h000;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
    end
    else if (do_write)
    begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr[11:0];
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
    end
  end

  assign do_write = aw_held && w_held;
  assign wr_line  = aw_addr[7:5];
  assign wr_cfg_hit = aw_addr[11:8] == 4'h0 && wr_line < 3'(NL)
    && aw_addr[4:0] == 5'(`OFS_CONFIG);
  assign wr_thr_hit = aw_addr[11:8] == 4'h0 && wr_line < 3'(NL)
    && aw_addr[4:0] == 5'(`OFS_THRESHOLD);
  assign wr_glob_hit = aw_addr >= `OFS_OUTPUTS
    && aw_addr <= `OFS_LINE_STATE && aw_addr[1:0] == 2'b00;

  // Byte lanes of the write
  always_comb
  begin
    for (int b = 0; b < 4; b++)
      wmask[b*8 +: 8] = {8{w_strb[b]}};
  end

  // Write response; unmapped addresses get SLVERR
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (wr_cfg_hit || wr_thr_hit || wr_glob_hit)
        ? 2'b00 : 2'b10;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // ----------------------------------------
  // Line registers and detectors
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < NL; g++)
    begin : gen_line
      logic [31:0] merged;

      assign cfg_word[g] = {4'h0, line_cond[g], 4'h0, line_resp[g],
        line_chan[g], 2'b00, line_sens[g], 1'b0, line_type[g],
        3'b000, line_en[g]};
      assign merged = (cfg_word[g] & ~wmask) | (w_data & wmask);

      // Fields store raw codes; software keeps them in range
      always_ff @(posedge clk_sys)
      begin
        if (!resetn)
        begin
          line_en[g]   <= 1'b0;
          line_type[g] <= trig_in_pkg::type_rise;
          line_sens[g] <= trig_in_pkg::sens_low;
          line_chan[g] <= 4'h0;
          line_resp[g] <= trig_in_pkg::resp_output_on;
          line_cond[g] <= trig_in_pkg::cond_output_off;
          line_thr[g]  <= 32'h0000_0000;
        end
        else if (do_write && wr_line == 3'(g))
        begin
          if (wr_cfg_hit)
          begin
            line_en[g]   <= merged[`CFG_EN_BIT];
            line_type[g] <= trig_in_pkg::trig_type_t'(
              merged[`CFG_TYPE_LSB +: 3]);
            line_sens[g] <= trig_in_pkg::sens_t'(
              merged[`CFG_SENS_LSB +: 2]);
            line_chan[g] <= merged[`CFG_CHAN_LSB +: 4];
            line_resp[g] <= trig_in_pkg::resp_t'(
              merged[`CFG_RESP_LSB +: 4]);
            line_cond[g] <= trig_in_pkg::out_cond_t'(
              merged[`CFG_COND_LSB +: 4]);
          end
          if (wr_thr_hit)
            line_thr[g] <= (line_thr[g] & ~wmask) | (w_data & wmask);
        end
      end

      trig_line_detect u_detect
      (
        .clk_sys   (clk_sys),
        .resetn    (resetn),
        .line_pin  (trig_pin[g]),
        .enable    (line_en[g]),
        .trig_type (line_type[g]),
        .fire      (fire[g])
      );
    end
  endgenerate

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  assign rd_line = s_axi_araddr[7:5];

  // Every setting reads back from its own word
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    rd_ok      = 1'b1;
    if (s_axi_araddr[11:8] == 4'h0 && rd_line < 3'(NL)
      && s_axi_araddr[4:0] == 5'(`OFS_CONFIG))
      next_rdata = cfg_word[rd_line];
    else if (s_axi_araddr[11:8] == 4'h0 && rd_line < 3'(NL)
      && s_axi_araddr[4:0] == 5'(`OFS_THRESHOLD))
      next_rdata = line_thr[rd_line];
    else if (s_axi_araddr[11:0] == `OFS_OUTPUTS)
      next_rdata = {28'h0, chan_output_on};
    else if (s_axi_araddr[11:0] == `OFS_LOADMODE)
      next_rdata = {24'h0, chan_mode};
    else if (s_axi_araddr[11:0] == `OFS_COUPLING)
      next_rdata = {30'h0, pair_coupling};
    else if (s_axi_araddr[11:0] == `OFS_LINE_STATE)
      next_rdata = {27'h0, fire_seen};
    else
      rd_ok = 1'b0;
  end

  // Read data registered; holds until taken
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'b00;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= next_rdata;
      s_axi_rresp  <= rd_ok ? 2'b00 : 2'b10;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // ----------------------------------------
  // Response actions on channel state
  // ----------------------------------------
  logic [3:0]    next_on;
  logic [7:0]    next_mode;
  logic [1:0]    next_coup;

  // Sticky record of which lines fired; writing ones there clears those bits
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
      fire_seen <= '0;
    else if (do_write && aw_addr == `OFS_LINE_STATE)
      fire_seen <= (fire_seen & ~w_data[NL-1:0]) | fire;
    else
      fire_seen <= fire_seen | fire;
  end

  // Lines applied in order; a higher line wins on a shared channel
  always_comb
  begin
    next_on   = chan_output_on;
    next_mode = chan_mode;
    next_coup = pair_coupling;
    if (do_write && aw_addr == `OFS_OUTPUTS)
      next_on = (chan_output_on & ~wmask[3:0]) | (w_data[3:0] & wmask[3:0]);
    for (int l = 0; l < NL; l++)
    begin
      if (fire[l])
      begin
        for (int c = 0; c < NC; c++)
        begin
          if (line_chan[l][c])
          begin
            case (line_resp[l])
              trig_in_pkg::resp_output_on:  next_on[c] = 1'b1;
              trig_in_pkg::resp_output_off: next_on[c] = 1'b0;
              trig_in_pkg::resp_toggle:     next_on[c] = ~next_on[c];
              trig_in_pkg::resp_source:
                next_mode[c*2 +: 2] = 2'(trig_in_pkg::mode_source);
              trig_in_pkg::resp_load_const_voltage:
                next_mode[c*2 +: 2] = 2'(trig_in_pkg::mode_load_const_voltage);
              trig_in_pkg::resp_load_const_current:
                next_mode[c*2 +: 2] = 2'(trig_in_pkg::mode_load_const_current);
              trig_in_pkg::resp_load_const_resistance:
                next_mode[c*2 +: 2] =
                  2'(trig_in_pkg::mode_load_const_resistance);
              default: ;
            endcase
          end
        end
        // Pair coupling needs both first channels selected
        if (line_chan[l][1:0] == 2'b11)
        begin
          case (line_resp[l])
            trig_in_pkg::resp_independent_coupling:
              next_coup = 2'(trig_in_pkg::independent_coupling);
            trig_in_pkg::resp_series_coupling:
              next_coup = 2'(trig_in_pkg::series_coupling);
            trig_in_pkg::resp_parallel_coupling:
              next_coup = 2'(trig_in_pkg::parallel_coupling);
            default: ;
          endcase
        end
      end
    end
  end

  // Channel state registers
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      chan_output_on <= 4'h0;
      chan_mode      <= 8'h00;
      pair_coupling  <= 2'b00;
    end
    else
    begin
      chan_output_on <= next_on;
      chan_mode      <= next_mode;
      pair_coupling  <= next_coup;
    end
  end
endmodule : trig_in_ctrl

// ### tb/trig_src_model.sv
module trig_src_model
(
  input  logic       clk_sys,
  output logic [4:0] trig_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Trigger line drive
  // ----------------------------------------
  // Pins are driven to a defined level at all times, never floated
  initial trig_pin = 5'h00;
  // Each level stands 16 cycles, far past the synchroniser depth
  task set_line(input int n, input logic v);
    @(posedge clk_sys);
    trig_pin[n] <= v;
    repeat (16) @(posedge clk_sys);
  endtask : set_line
endmodule : trig_src_model

// ### tb/trig_in_ctrl_assertions.sv
module trig_in_ctrl_assertions
(
  input logic        clk_sys,
  input logic        resetn,
  input logic [4:0]  trig_pin,
  input logic        s_axi_awvalid,
  input logic        s_axi_awready,
  input logic        s_axi_wvalid,
  input logic        s_axi_wready,
  input logic        s_axi_bvalid,
  input logic        s_axi_bready,
  input logic        s_axi_arvalid,
  input logic        s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic [1:0]  s_axi_rresp,
  input logic        s_axi_rvalid,
  input logic [3:0]  chan_output_on,
  input logic [7:0]  chan_mode,
  input logic [1:0]  pair_coupling
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // ----------------------------------------
  // Sequences
  // ----------------------------------------
  // No write offered and pins still long enough for any fire to land
  sequence quiet_s;
    (!s_axi_awvalid && !s_axi_wvalid && $stable(trig_pin)) [*8];
  endsequence
  sequence read_take_s;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence both_take_s;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_reset_clears: assert property ($rose(resetn) |->
    chan_output_on == 4'h0 && chan_mode == 8'h00 && pair_coupling == 2'h0
    && !s_axi_rvalid) else $error("outputs not clear after reset");
  a_quiet_stable: assert property (quiet_s |-> $stable(chan_output_on)
    && $stable(chan_mode) && $stable(pair_coupling))
    else $error("outputs moved with no cause");
  a_read_answer: assert property (read_take_s |=> s_axi_rvalid)
    else $error("read not answered next cycle");
  a_write_answer: assert property (both_take_s |-> ##[1:2] s_axi_bvalid)
    else $error("write not answered in time");
  a_read_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  a_write_refuse: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready) else $error("write taken early");
  a_one_response: assert property (s_axi_bvalid && s_axi_bready
    |=> !s_axi_bvalid) else $error("write answered twice");
  a_unmapped_zero: assert property (s_axi_rvalid &&
    s_axi_rresp == 2'b10 |-> s_axi_rdata == 32'h0)
    else $error("error read returned data");
  a_coupling_legal: assert property (pair_coupling != 2'b11)
    else $error("coupling code out of range");
endmodule : trig_in_ctrl_assertions

bind trig_in_ctrl trig_in_ctrl_assertions chk
(
  .clk_sys, .resetn, .trig_pin, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .chan_output_on, .chan_mode, .pair_coupling
);

// ### tb/tb_trig_in_ctrl.sv
module tb_trig_in_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys, resetn, s_axi_awvalid, s_axi_awready;
  logic        s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rnd;
  logic [1:0]  s_axi_bresp, s_axi_rresp, pair_coupling, e_cpl;
  logic [4:0]  trig_pin;
  logic [3:0]  chan_output_on, e_on;
  logic [7:0]  chan_mode, e_mode;
  logic [33:0] exp_q[$];
  int          mismatches = 0;
  int          samples_checked = 0;

  trig_in_ctrl dut
  (
    .clk_sys, .resetn, .trig_pin, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .chan_output_on,
    .chan_mode, .pair_coupling
  );
  trig_src_model src (.clk_sys, .trig_pin);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    lfsr = x[0] ? (x >> 1) ^ 32'h80200003 : x >> 1;
  endfunction : lfsr
  // Line config word: enable, type, sensitivity, mask, response, condition
  function automatic logic [31:0] cfg(input logic e, input logic [2:0] t,
    input logic [1:0] s, input logic [3:0] m, r, c);
    cfg = {4'h0, c, 4'h0, r, m, 2'h0, s, 1'b0, t, 3'h0, e};
  endfunction : cfg
  task chk_read(input logic [33:0] e, input logic [33:0] g);
    samples_checked++;
    if (g !== e)
    begin
      mismatches++;
      $display("unexpected read data exp %h got %h", e, g);
    end
  endtask : chk_read
  task chk_resp(input logic [1:0] g);
    samples_checked++;
    if (g !== 2'b00)
    begin
      mismatches++;
      $display("unexpected write response exp %h got %h", 2'b00, g);
    end
  endtask : chk_resp
  task chk_port;
    samples_checked++;
    if ({chan_output_on, chan_mode, pair_coupling} !== {e_on, e_mode, e_cpl})
    begin
      mismatches++;
      $display("unexpected ports exp %h %h %h got %h %h %h", e_on, e_mode,
        e_cpl, chan_output_on, chan_mode, pair_coupling);
    end
  endtask : chk_port
  // Leading edge keeps a new request off the edge that closed the last one
  task wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever
    begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
  endtask : wr
  task rd(input logic [31:0] a, input logic [33:0] e);
    @(posedge clk_sys);
    exp_q.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever
    begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
  endtask : rd
  task pulse(input int n);
    src.set_line(n, 1'b1);
    src.set_line(n, 1'b0);
  endtask : pulse
  task wrap_up;
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : wrap_up

  // ----------------------------------------
  // Clock, monitor, watchdog
  // ----------------------------------------
  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // Read answers are matched in order against the noted expectations
  always @(posedge clk_sys)
    if (s_axi_rvalid && s_axi_rready)
      chk_read(exp_q.pop_front(), {s_axi_rresp, s_axi_rdata});
  // Every bench write goes to a mapped word, so each answer is OKAY
  always @(posedge clk_sys)
    if (s_axi_bvalid && s_axi_bready)
      chk_resp(s_axi_bresp);
  // Whole run needs about 500 cycles; twelve times that means a hang
  initial
  begin
    repeat (6000) @(posedge clk_sys);
    mismatches++;
    wrap_up();
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial
  begin
    {resetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr} = 34'h0;
    {s_axi_wdata, s_axi_araddr} = 64'h0;
    {e_on, e_mode, e_cpl} = 14'h0;
    rnd = 32'h2320818E;
    repeat (4) @(posedge clk_sys);
    resetn <= 1'b1;
    // Random legal fields, line disabled so nothing fires
    for (int n = 0; n < 5; n++)
    begin
      rnd = lfsr(rnd);
      s_axi_wdata <= cfg(1'b0, 3'(rnd[2:0] % 5), 2'(rnd[5:4] % 3),
        rnd[11:8], 4'(rnd[19:16] % 10), 4'(rnd[27:24] % 12));
      @(posedge clk_sys);
      wr(32'(n) * 32'h20, s_axi_wdata);
      rd(32'(n) * 32'h20, {2'b00, s_axi_wdata});
      wr(32'(n) * 32'h20 + 32'h4, rnd);
      rd(32'(n) * 32'h20 + 32'h4, {2'b00, rnd});
    end
    rd(32'h200, {2'b10, 32'h0});
    $display("config readback done");
    wr(32'h000, cfg(1'b1, 3'h0, 2'h0, 4'h5, 4'h0, 4'h0));
    pulse(0);
    e_on = 4'h5;
    chk_port();
    wr(32'h020, cfg(1'b1, 3'h1, 2'h0, 4'h1, 4'h1, 4'h0));
    pulse(1);
    e_on = 4'h4;
    chk_port();
    $display("output on and off done");
    // High level held long: a second toggle would show a refire
    wr(32'h040, cfg(1'b1, 3'h2, 2'h0, 4'hC, 4'h2, 4'h0));
    src.set_line(2, 1'b1);
    repeat (20) @(posedge clk_sys);
    e_on = 4'h8;
    chk_port();
    // Dropping the level re-arms without firing; the next high toggles
    src.set_line(2, 1'b0);
    chk_port();
    pulse(2);
    e_on = 4'h4;
    chk_port();
    rd(32'h100, {30'h0, e_on});
    wr(32'h060, cfg(1'b0, 3'h0, 2'h0, 4'hF, 4'h0, 4'h0));
    pulse(3);
    chk_port();
    $display("toggle and disable done");
    // State type: every pin change fires; source last so its change shows
    for (int k = 4; k < 8; k++)
    begin
      wr(32'h060, cfg(1'b1, 3'h4, 2'h0, 4'hF, 4'(k % 7 + k / 7 * 3), 4'h0));
      src.set_line(3, ~k[0]);
      e_mode = {4{2'(k - 3)}};
      chk_port();
    end
    rd(32'h104, {26'h0, e_mode});
    for (int k = 8; k < 11; k++)
    begin
      wr(32'h080, cfg(1'b1, 3'h0, 2'h0, 4'h3, 4'(k % 10 + k / 10 * 7),
        4'h0));
      pulse(4);
      e_cpl = 2'(k % 10 + k / 10 * 7 - 7);
      chk_port();
    end
    rd(32'h108, {32'h0, e_cpl});
    $display("mode and coupling done");
    wrap_up();
  end
endmodule : tb_trig_in_ctrl
